/* rbs_board.sv */
// board model: reset button and strap pins
`timescale 1ns/100ps
`default_nettype none
module rbs_board (
   input wire logic clk,
   input wire logic hold_rst,
   input wire logic boot_lvl,
   input wire logic tri_lvl,
   output logic rst_n,
   output logic boot_pin,
   output logic tri_pin_n
);
   logic rst_reg = 1'b0;
   logic tog_reg = 1'b0;
   logic [3:0] run_cnt = 4'h0;
   // release only after ten running clock cycles and the bench's hold time
   always @(posedge clk) begin
      if (run_cnt != 4'ha) run_cnt <= run_cnt + 4'h1;
      rst_reg <= !hold_rst && run_cnt == 4'ha;
      tog_reg <= !tog_reg;
   end
   assign rst_n = rst_reg;
   // straps drive only in reset; afterwards the lines carry io traffic
   assign boot_pin = rst_reg ? tog_reg : boot_lvl;
   assign tri_pin_n = rst_reg ? !tog_reg : tri_lvl;
endmodule // rbs_board
`default_nettype wire

/* rbs_pkg.sv */
// package for the reset, boot-mode and address decode sequencer
package rbs_pkg;

   // sampling windows and delays, in master clock cycles, and the counter width in bits
   localparam int BOOT_WIN_CYC = 10;
   localparam int TRI_WIN_CYC = 80;
   localparam int FETCH_DELAY_CYC = 80;
   localparam int SYNC_STAGES = 2;
   localparam int WDT_HOLD_CYC = 4;
   localparam int CNT_W = 7;

   // register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] STATUS_OFS = 4'h4;
   localparam logic [3:0] IO_OE_OFS = 4'h8;
   localparam logic [3:0] CHIP_ID_OFS = 4'hc;

   // control bits
   localparam int CTRL_REMAP_BIT = 0;
   localparam int CTRL_WPROT_BIT = 1;
   localparam int CTRL_CLK_OUT_IO_BIT = 2;

   // status bits
   localparam int ST_BOOT_BIT = 0;
   localparam int ST_TRI_BIT = 1;
   localparam int ST_WDT_CAUSE_BIT = 2;
   localparam int ST_WDET_BIT = 3;
   localparam int ST_FETCH_BIT = 4;

   // arbitrary identifier value
   localparam logic [31:0] CHIP_ID_VAL = 32'h5a5a_0001;

   // memory map
   localparam logic [31:0] INT_MEM_TOP = 32'h003f_ffff;
   localparam logic [31:0] PERIPH_BASE = 32'hffc0_0000;
   localparam logic [31:0] PRI_SRAM_SIZE = 32'h0000_2000;
   localparam logic [31:0] PRI_SRAM_ALT_BASE = 32'h0030_0000;
   localparam logic [31:0] EXT_SRAM_BASE = 32'h0010_0000;
   localparam logic [31:0] EXT_SRAM_SIZE = 32'h0002_0000;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;

   typedef enum logic [2:0] {
      REG_NONE, REG_PRI_SRAM, REG_EXT_SRAM, REG_EXT_BUS_CS0, REG_EXT_BUS, REG_PERIPH,
      REG_INT_UNDEF
   } rbs_region_t;

   typedef struct packed {
      logic valid;
      logic write;
      rbs_region_t region;
      logic [3:0] byte_en;
   } rbs_dec_t;

   typedef struct packed {
      logic [31:0] addr;
      logic req;
      logic we;
      logic [1:0] size;
   } rbs_core_req_t;

endpackage

/* rbs_sequencer.sv */
// reset, boot-mode, tri-state sequencer with address decoder and wishbone registers
// How it works
// RL1: external reset acts asynchronously; its release is synchronised to the clock.
// RL2: board keeps the clock running ten cycles before reset rises.
// RL3: first instruction fetch comes eighty cycles after external reset rises.
// RL4: any reset restores register defaults; core restarts fetching at address zero.
// RL5: watchdog reset acts like external reset but leaves both strap modes untouched.
// RL6: external reset wins over a simultaneous watchdog reset.
// RL7: tri-state select low for last eighty cycles disables every output driver.
// RL8: board holds tri-state select high during reset for normal operation.
// RL9: tri-state pin is shared with io line 21 and serial transmit after reset.
// RL10: boot-select level over the last ten cycles before release picks boot memory.
// RL11: boot-select one boots from the internal extended SRAM.
// RL12: boot-select zero boots from external memory on chip select zero.
// RL13: after reset the boot-select pin is general io line 24.
// RL14: clock output copies the master clock until the io controller takes it.
// RL15: after reset all peripheral io pins are inputs.
// RL16: decode lowest 4 MB internal, highest 4 MB peripherals, middle external bus.
// RL17: all regions use little-endian byte ordering.
// RL18: primary 8 KB SRAM sits at address zero after the remap command.
// RL19: primary SRAM completes byte, half-word and word access in one cycle.
// RL20: 128 KB extended SRAM starts at 0x0010_0000.
// RL21: writes to the extended SRAM are detected while protection is on.
// RL22: identification read returns a non-standard chip identifier.
// RL23: remap, once set, is cleared only by an internal or external reset.
// RL24: strap modes latch at reset release and hold until next external reset.
`timescale 1ns/100ps
`default_nettype none
module rbs_sequencer (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic WDT_RESET,
   input wire logic BOOT_SELECT,
   input wire logic TRISTATE_SELECT_N,
   input wire rbs_pkg::rbs_core_req_t CORE_REQ,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic WB_ACK_O,
   output logic [31:0] WB_DAT_O,
   output logic PERIPH_RESET_N,
   output logic CORE_FETCH_EN,
   output logic BOOT_FROM_EXT_SRAM,
   output logic TRISTATE_MODE,
   output logic OUTPUT_DRIVERS_EN,
   output logic CLK_OUT_IS_CLOCK,
   output logic STRAP_PINS_GPIO,
   output logic [31:0] IO_OUT_EN,
   output rbs_pkg::rbs_dec_t DEC,
   output logic WRITE_DETECT
);
   import rbs_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0] sync;
      logic rel_prev;
      logic [CNT_W-1:0] wdt_cnt;
      logic [CNT_W-1:0] fetch_cnt;
      logic periph_rst_n;
      logic fetch_en;
      logic boot_mode;
      logic tri_mode;
      logic wdt_cause;
      logic remap;
      logic wprot;
      logic clk_out_io;
      logic wdet;
      logic [31:0] io_oe;
      logic ack;
      logic [31:0] rdata;
      rbs_dec_t dec;
      logic drv_en;
      logic clk_out_run;
      logic [31:0] io_out;
   } rbs_state_t;

   // state while the reset pin is low; drivers on and clock pin running
   localparam rbs_state_t ST_RESET = '{
      sync: '0,
      rel_prev: 1'b0,
      wdt_cnt: '0,
      fetch_cnt: '0,
      periph_rst_n: 1'b0,
      fetch_en: 1'b0,
      boot_mode: 1'b0,
      tri_mode: 1'b0,
      wdt_cause: 1'b0,
      remap: 1'b0,
      wprot: 1'b0,
      clk_out_io: 1'b0,
      wdet: 1'b0,
      io_oe: '0,
      ack: 1'b0,
      rdata: '0,
      dec: '{
         valid: 1'b0,
         write: 1'b0,
         region: REG_NONE,
         byte_en: 4'h0
      },
      drv_en: 1'b1,
      clk_out_run: 1'b1,
      io_out: '0
   };

   typedef struct packed {
      logic [CNT_W-1:0] boot_hi_cnt;
      logic [CNT_W-1:0] tri_lo_cnt;
      logic boot_cap;
      logic tri_cap;
   } rbs_hist_t;

   rbs_state_t st_reg;
   rbs_state_t st_next;
   rbs_hist_t hist_reg;
   rbs_hist_t hist_next;

   logic ext_released;
   logic int_rst;
   logic wb_req;
   logic [31:0] wmask;
   logic [31:0] a;

   assign ext_released = st_reg.sync[SYNC_STAGES-1];
   assign int_rst = !ext_released || (st_reg.wdt_cnt != '0);
   assign wb_req = WB_CYC_I && WB_STB_I && !st_reg.ack;
   assign a = CORE_REQ.addr;

   generate
      for (genvar i = 0; i < 4; i++) begin : g_mask
         assign wmask[8*i +: 8] = {8{WB_SEL_I[i]}};
      end
   endgenerate

   // strap pin history; runs on every clock, also while reset is held
   always_comb begin
      hist_next = hist_reg;
      if (BOOT_SELECT) begin
         if (hist_reg.boot_hi_cnt != CNT_W'(BOOT_WIN_CYC)) begin
            hist_next.boot_hi_cnt = hist_reg.boot_hi_cnt + 1'b1; // RL10
         end
      end else begin
         hist_next.boot_hi_cnt = '0;
      end
      if (!TRISTATE_SELECT_N) begin
         if (hist_reg.tri_lo_cnt != CNT_W'(TRI_WIN_CYC)) begin
            hist_next.tri_lo_cnt = hist_reg.tri_lo_cnt + 1'b1; // RL7
         end
      end else begin
         hist_next.tri_lo_cnt = '0;
      end
      // verdict frozen at the last edge with the reset pin low; pins carry io after
      if (!RESETN) begin
         hist_next.boot_cap = (hist_next.boot_hi_cnt == CNT_W'(BOOT_WIN_CYC)); // RL10
         hist_next.tri_cap = (hist_next.tri_lo_cnt == CNT_W'(TRI_WIN_CYC)); // RL7
      end
   end

   always_ff @(posedge CLK) begin
      hist_reg <= hist_next;
   end

   always_comb begin
      st_next = st_reg;
      st_next.sync = {st_reg.sync[SYNC_STAGES-2:0], 1'b1}; // RL1
      st_next.rel_prev = ext_released;
      // latch straps only on external release, never on watchdog
      if (ext_released && !st_reg.rel_prev) begin
         st_next.boot_mode = hist_reg.boot_cap; // RL10 RL24
         st_next.tri_mode = hist_reg.tri_cap; // RL7 RL24
         st_next.wdt_cause = 1'b0;
      end
      // watchdog reset hold
      if (st_reg.wdt_cnt != '0) begin
         st_next.wdt_cnt = st_reg.wdt_cnt - 1'b1;
      end
      if (WDT_RESET && ext_released) begin
         st_next.wdt_cnt = CNT_W'(WDT_HOLD_CYC); // RL5 RL6
         st_next.wdt_cause = 1'b1;
      end
      st_next.periph_rst_n = !int_rst;
      // fetch delay counted from reset release
      if (int_rst) begin
         st_next.fetch_cnt = '0;
         st_next.fetch_en = 1'b0;
      end else if (st_reg.fetch_cnt != CNT_W'(FETCH_DELAY_CYC - SYNC_STAGES - 1)) begin
         st_next.fetch_cnt = st_reg.fetch_cnt + 1'b1;
      end else begin
         st_next.fetch_en = 1'b1; // RL3
      end
      // wishbone slave, one wait state, ack for one cycle
      st_next.ack = wb_req;
      st_next.rdata = '0;
      if (wb_req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            CTRL_OFS: begin
               st_next.rdata[CTRL_REMAP_BIT] = st_reg.remap;
               st_next.rdata[CTRL_WPROT_BIT] = st_reg.wprot;
               st_next.rdata[CTRL_CLK_OUT_IO_BIT] = st_reg.clk_out_io;
            end
            STATUS_OFS: begin
               st_next.rdata[ST_BOOT_BIT] = st_reg.boot_mode;
               st_next.rdata[ST_TRI_BIT] = st_reg.tri_mode;
               st_next.rdata[ST_WDT_CAUSE_BIT] = st_reg.wdt_cause;
               st_next.rdata[ST_WDET_BIT] = st_reg.wdet;
               st_next.rdata[ST_FETCH_BIT] = st_reg.fetch_en;
            end
            IO_OE_OFS: st_next.rdata = st_reg.io_oe;
            CHIP_ID_OFS: st_next.rdata = CHIP_ID_VAL; // RL22
            default: st_next.rdata = '0;
         endcase
      end
      if (wb_req && WB_WE_I) begin
         unique case (WB_ADR_I)
            CTRL_OFS: begin
               if (WB_SEL_I[0]) begin
                  // remap can only be set by software
                  st_next.remap = st_reg.remap | WB_DAT_I[CTRL_REMAP_BIT]; // RL23
                  st_next.wprot = WB_DAT_I[CTRL_WPROT_BIT];
                  st_next.clk_out_io = WB_DAT_I[CTRL_CLK_OUT_IO_BIT]; // RL14
               end
            end
            STATUS_OFS: begin
               if (WB_SEL_I[0] && WB_DAT_I[ST_WDET_BIT]) begin
                  st_next.wdet = 1'b0;
               end
            end
            IO_OE_OFS: st_next.io_oe = (st_reg.io_oe & ~wmask) | (WB_DAT_I & wmask);
            default: st_next.io_oe = st_reg.io_oe;
         endcase
      end
      // address decode, registered one cycle
      st_next.dec.valid = CORE_REQ.req && st_reg.fetch_en;
      st_next.dec.write = CORE_REQ.we;
      if (a <= INT_MEM_TOP) begin // RL16
         if (a < PRI_SRAM_SIZE) begin
            if (st_reg.remap) begin
               st_next.dec.region = REG_PRI_SRAM; // RL18
            end else if (st_reg.boot_mode) begin
               st_next.dec.region = REG_EXT_SRAM; // RL11
            end else begin
               st_next.dec.region = REG_EXT_BUS_CS0; // RL12
            end
         end else if (a >= EXT_SRAM_BASE && a < EXT_SRAM_BASE + EXT_SRAM_SIZE) begin
            st_next.dec.region = REG_EXT_SRAM; // RL20
         end else if (a >= PRI_SRAM_ALT_BASE && a < PRI_SRAM_ALT_BASE + PRI_SRAM_SIZE) begin
            st_next.dec.region = REG_PRI_SRAM;
         end else begin
            st_next.dec.region = REG_INT_UNDEF;
         end
      end else if (a >= PERIPH_BASE) begin
         st_next.dec.region = REG_PERIPH;
      end else begin
         st_next.dec.region = REG_EXT_BUS;
      end
      // little-endian lane select, all sizes in one cycle
      unique case (CORE_REQ.size)
         SIZE_BYTE: st_next.dec.byte_en = 4'h1 << a[1:0]; // RL17 RL19
         SIZE_HALF: st_next.dec.byte_en = a[1] ? 4'hc : 4'h3; // RL17 RL19
         default: st_next.dec.byte_en = 4'hf;
      endcase
      if (!st_next.dec.valid) begin
         st_next.dec.region = REG_NONE;
      end
      // write detection; a new hit wins over a clear
      if (st_next.dec.valid && CORE_REQ.we && st_reg.wprot &&
          st_next.dec.region == REG_EXT_SRAM) begin
         st_next.wdet = 1'b1; // RL21
      end
      // any reset restores register defaults
      if (int_rst) begin
         st_next.remap = 1'b0; // RL4 RL23
         st_next.wprot = 1'b0;
         st_next.clk_out_io = 1'b0;
         st_next.wdet = 1'b0;
         st_next.io_oe = '0; // RL15
         st_next.ack = 1'b0;
         st_next.dec.valid = 1'b0;
         st_next.dec.region = REG_NONE;
      end
      // pad controls follow the next state so every output leaves a flip-flop
      st_next.drv_en = !st_next.tri_mode; // RL7
      st_next.clk_out_run = !st_next.clk_out_io; // RL14
      st_next.io_out = st_next.tri_mode ? '0 : st_next.io_oe; // RL7 RL15
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_reg <= ST_RESET; // RL1 RL6
      end else begin
         st_reg <= st_next;
      end
   end

   assign WB_ACK_O = st_reg.ack;
   assign WB_DAT_O = st_reg.rdata;
   assign PERIPH_RESET_N = st_reg.periph_rst_n;
   assign CORE_FETCH_EN = st_reg.fetch_en;
   assign BOOT_FROM_EXT_SRAM = st_reg.boot_mode;
   assign TRISTATE_MODE = st_reg.tri_mode;
   assign OUTPUT_DRIVERS_EN = st_reg.drv_en; // RL7
   assign CLK_OUT_IS_CLOCK = st_reg.clk_out_run; // RL14
   assign STRAP_PINS_GPIO = st_reg.periph_rst_n; // RL9 RL13
   assign IO_OUT_EN = st_reg.io_out; // RL7 RL15
   assign DEC = st_reg.dec;
   assign WRITE_DETECT = st_reg.wdet;

endmodule // rbs_sequencer
`default_nettype wire

/* rbs_sequencer_sva.sv */
// port assertions for the sequencer
`timescale 1ns/100ps
`default_nettype none
module rbs_checker (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic WDT_RESET,
   input wire rbs_pkg::rbs_core_req_t CORE_REQ,
   input wire logic PERIPH_RESET_N,
   input wire logic CORE_FETCH_EN,
   input wire logic BOOT_FROM_EXT_SRAM,
   input wire logic TRISTATE_MODE,
   input wire logic OUTPUT_DRIVERS_EN,
   input wire logic CLK_OUT_IS_CLOCK,
   input wire logic [31:0] IO_OUT_EN,
   input wire rbs_pkg::rbs_dec_t DEC
);
   import rbs_pkg::*;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESETN);
   rst_sync_a: assert property ($rose(RESETN) |-> !PERIPH_RESET_N[*3] ##1 PERIPH_RESET_N)
      else $error("reset release not synchronised");
   fetch_delay_a: assert property ($rose(RESETN) |-> ##79 !CORE_FETCH_EN ##1 CORE_FETCH_EN)
      else $error("first fetch not at cycle 80");
   wdt_hold_a: assert property (WDT_RESET && PERIPH_RESET_N |=>
      ##1 (!PERIPH_RESET_N && !CORE_FETCH_EN)[*3]) else $error("watchdog reset missing");
   mode_hold_a: assert property ($past(PERIPH_RESET_N) |->
      $stable({BOOT_FROM_EXT_SRAM, TRISTATE_MODE})) else $error("strap mode changed");
   tri_drive_a: assert property (TRISTATE_MODE |=> !OUTPUT_DRIVERS_EN && IO_OUT_EN == '0)
      else $error("drivers on in tri-state mode");
   reset_out_a: assert property (!PERIPH_RESET_N ##1 !PERIPH_RESET_N |->
      CLK_OUT_IS_CLOCK && IO_OUT_EN == '0) else $error("pin defaults wrong in reset");
   periph_dec_a: assert property (CORE_FETCH_EN && CORE_REQ.req && CORE_REQ.addr >= PERIPH_BASE
      |=> DEC.valid && DEC.region == REG_PERIPH) else $error("peripheral decode wrong");
   byte_lane_a: assert property (CORE_FETCH_EN && CORE_REQ.req && CORE_REQ.size == SIZE_BYTE
      |=> DEC.byte_en == (4'h1 << $past(CORE_REQ.addr[1:0]))) else $error("byte lane wrong");
endmodule // rbs_checker
bind rbs_sequencer rbs_checker chk_u (.*);
`default_nettype wire

/* rbs_sequencer_tb.sv */
// testbench for the reset and boot-mode sequencer
`timescale 1ns/100ps
`default_nettype none
module rbs_sequencer_tb;
   import rbs_pkg::*;
   logic clk = 1'b0, hold_rst = 1'b1, boot_lvl = 1'b0, tri_lvl = 1'b1, wdt = 1'b0;
   logic cs = 1'b0, we = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dout, oe;
   logic rst_n, boot_pin, tri_pin_n, ack, prst_n, fetch, boot_m, tri_m, drv_en, clk_out, gpio, wdet;
   rbs_core_req_t req = '0;
   rbs_dec_t dec;
   int num_errors = 0, compares = 0;
   rbs_board board_u (.clk(clk), .hold_rst(hold_rst), .boot_lvl(boot_lvl), .tri_lvl(tri_lvl),
      .rst_n(rst_n), .boot_pin(boot_pin), .tri_pin_n(tri_pin_n));
   rbs_sequencer dut_u (.CLK(clk), .RESETN(rst_n), .WDT_RESET(wdt), .BOOT_SELECT(boot_pin),
      .TRISTATE_SELECT_N(tri_pin_n), .CORE_REQ(req), .WB_CYC_I(cs), .WB_STB_I(cs),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_ACK_O(ack),
      .WB_DAT_O(dout), .PERIPH_RESET_N(prst_n), .CORE_FETCH_EN(fetch),
      .BOOT_FROM_EXT_SRAM(boot_m), .TRISTATE_MODE(tri_m), .OUTPUT_DRIVERS_EN(drv_en),
      .CLK_OUT_IS_CLOCK(clk_out), .STRAP_PINS_GPIO(gpio), .IO_OUT_EN(oe), .DEC(dec),
      .WRITE_DETECT(wdet));
   initial begin
      forever #50 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cs <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n == 50) num_errors++;
      rdat = dout;
      cs <= 1'b0;
      @(posedge clk);
   endtask
   task automatic core(input logic [31:0] a, input logic [1:0] s, input logic w,
         input rbs_region_t r, input logic [3:0] be);
      req <= '{addr: a, req: 1'b1, we: w, size: s};
      @(posedge clk);
      req.req <= 1'b0;
      @(negedge clk);
      chk({dec.valid, dec.write, dec.region, dec.byte_en}, {1'b1, w, r, be});
      @(posedge clk);
   endtask
   task automatic ext_rst(input logic b, input logic t);
      boot_lvl <= b;
      tri_lvl <= t;
      hold_rst <= 1'b1;
      repeat (100) begin
         @(posedge clk);
         wdt <= 1'b0;
      end
      hold_rst <= 1'b0;
      repeat (90) @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #1000000;
      num_errors++;
      wrap_up;
   end
   initial begin
      repeat (2) @(posedge clk);
      hold_rst <= 1'b0;
      repeat (90) @(posedge clk);
      chk(fetch, 1'b1);
      chk({boot_m, tri_m, drv_en, gpio}, 4'h3);
      ext_rst(1'b1, 1'b1);
      chk({boot_m, tri_m, clk_out, gpio}, 4'hb);
      wb(1'b0, CHIP_ID_OFS, 32'h0);
      chk(rdat, CHIP_ID_VAL);
      wb(1'b0, 4'h2, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b1, IO_OE_OFS, 32'h0000_ffff);
      chk(oe, 32'h0000_ffff);
      wb(1'b1, CTRL_OFS, 32'h7);
      chk(clk_out, 1'b0);
      core(32'h0000_0004, 2'h2, 1'b0, REG_PRI_SRAM, 4'hf);
      core(32'h0010_0002, SIZE_HALF, 1'b1, REG_EXT_SRAM, 4'hc);
      chk(wdet, 1'b1);
      core(32'h0012_0000, 2'h2, 1'b0, REG_INT_UNDEF, 4'hf);
      core(32'h0040_0001, SIZE_BYTE, 1'b0, REG_EXT_BUS, 4'h2);
      core(32'hffc0_0003, SIZE_BYTE, 1'b0, REG_PERIPH, 4'h8);
      wb(1'b1, CTRL_OFS, 32'h0);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk(rdat[0], 1'b1);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      repeat (90) @(posedge clk);
      chk({fetch, boot_m, wdet, clk_out}, 4'hd);
      chk(oe, 32'h0);
      wb(1'b0, CTRL_OFS, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, STATUS_OFS, 32'h0);
      chk(rdat[ST_WDT_CAUSE_BIT], 1'b1);
      wdt <= 1'b1;
      ext_rst(1'b0, 1'b0);
      chk({boot_m, tri_m, drv_en, gpio}, 4'h5);
      wb(1'b1, IO_OE_OFS, 32'hffff_ffff);
      chk(oe, 32'h0);
      core(32'h0000_0000, 2'h2, 1'b0, REG_EXT_BUS_CS0, 4'hf);
      wrap_up;
   end
endmodule // rbs_sequencer_tb
`default_nettype wire
